/* File: hdl/vrc_pkg.sv */
// Shared constants for the video RAM controller core and its host end
package vrc_pkg;
	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int CLK_NS = 10;
	localparam int ROW_W = 11;
	localparam int COL_W = 11;
	localparam int NBANK = 4;
	localparam int CFG_W = 10;
	localparam int CNT_W = 4;
	localparam int XCNT_W = 3;
	localparam int RTIM_W = 11;
	localparam int LEAD_W = 5;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam logic [XCNT_W-1:0] XFER_EDGES = 3'h4;
	localparam logic [CNT_W-1:0] RAH_CYC = 4'h1;
	localparam logic [CNT_W-1:0] CAS_CYC = 4'h2;
	localparam int RAS_LOW_NS = 80;
	localparam logic [CNT_W-1:0] RAS_LOW_CYC =
		CNT_W'((RAS_LOW_NS + CLK_NS - 1) / CLK_NS);
	localparam int PRE_NS = 70;
	localparam logic [CNT_W-1:0] PRE_CYC =
		CNT_W'((PRE_NS + CLK_NS - 1) / CLK_NS);
	localparam int REF_PERIOD_NS = 15600;
	localparam logic [RTIM_W-1:0] REF_CYC =
		RTIM_W'(REF_PERIOD_NS / CLK_NS);
	localparam logic [LEAD_W-1:0] XFER_LEAD_CYC = 5'h10;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
	localparam logic [CNT_W-1:0] STAG_EXTRA = 4'h3;
	// ------------------------------------------------------------
	// Programming word bit positions (taken from the row inputs)
	// ------------------------------------------------------------
	localparam int PB_WAIT_MODE = 0;
	localparam int PB_WAIT_LSB = 1;
	localparam int PB_TOGGLE = 3;
	localparam int PB_REF_LSB = 4;
	localparam int PB_BANK_LSB = 6;
	localparam int PB_TRANSP = 8;
	localparam int PB_PIPE = 9;
	localparam logic [CFG_W-1:0] CFG_RESET = 10'h000;
	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	localparam logic [1:0] REF_CONV = 2'h0;
	localparam logic [1:0] REF_STAG = 2'h1;
	localparam logic [1:0] REF_SCRUB = 2'h2;
	localparam logic [1:0] BANKS_1 = 2'h0;
	localparam logic [1:0] BANKS_2 = 2'h1;
	localparam logic [NBANK-1:0] ALL_BANKS = 4'hF;
	localparam logic [NBANK-1:0] SCRUB_CAS = 4'h1;
endpackage : vrc_pkg

/* File: hdl/vrc_if.sv */
// Pin bundle between the host logic and the controller core
`timescale 1ns/1ns
`default_nettype none
interface vrc_if;
	logic mode_load_n, chip_select_n, addr_latch_en, address_strobe_in_n;
	logic access_request_a_n, access_request_b_n, lock_n;
	logic [10:0] row_addr, col_addr, mem_addr;
	logic bank_select_low, bank_select_high, column_increment_in;
	logic [1:0] column_enable_inputs_n;
	logic advance_transfer_request, shift_reg_load_in_n;
	logic refresh_disable_in, refresh_request_in, refresh_extend_in;
	logic wait_extend_in_n;
	logic [3:0] ras_n, cas_n;
	logic transfer_output_enable_n, refresh_pin_n, ack_wait_n;
	logic port_b_access_ack_n, port_b_grant;
	modport dev(
		input mode_load_n, chip_select_n, addr_latch_en, address_strobe_in_n,
		input access_request_a_n, access_request_b_n, lock_n, row_addr,
		input col_addr, bank_select_low, bank_select_high,
		input column_increment_in, column_enable_inputs_n,
		input advance_transfer_request, shift_reg_load_in_n,
		input refresh_disable_in, refresh_request_in, refresh_extend_in,
		input wait_extend_in_n,
		output mem_addr, ras_n, cas_n, transfer_output_enable_n,
		output refresh_pin_n, ack_wait_n, port_b_access_ack_n, port_b_grant
	);
	modport host(
		output mode_load_n, chip_select_n, addr_latch_en, address_strobe_in_n,
		output access_request_a_n, access_request_b_n, lock_n, row_addr,
		output col_addr, bank_select_low, bank_select_high,
		output column_increment_in, column_enable_inputs_n,
		output advance_transfer_request, shift_reg_load_in_n,
		output refresh_disable_in, refresh_request_in, refresh_extend_in,
		output wait_extend_in_n,
		input mem_addr, ras_n, cas_n, transfer_output_enable_n,
		input refresh_pin_n, ack_wait_n, port_b_access_ack_n, port_b_grant
	);
endinterface : vrc_if
`default_nettype wire

/* File: hdl/vrc_prechg.sv */
// Per-bank row precharge counter
`timescale 1ns/1ns
`default_nettype none
module vrc_prechg (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_start,
	output logic o_busy
);
	import vrc_pkg::*;
	logic [CNT_W-1:0] cnt_ff;

	// Load on row strobe release, then count down to free
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			cnt_ff <= CNT_ZERO;
		else if (i_start)
			cnt_ff <= PRE_CYC;
		else if (cnt_ff != CNT_ZERO)
			cnt_ff <= cnt_ff - CNT_ONE;
	end

	assign o_busy = cnt_ff != CNT_ZERO;
endmodule : vrc_prechg
`default_nettype wire

/* File: hdl/vrc_dev_end.sv */
// Video RAM controller core: arbitration, strobes and address mux
`timescale 1ns/1ns
`default_nettype none
module vrc_dev_end (
	input wire logic i_clk,
	input wire logic i_resetn,
	vrc_if.dev bus,
	output logic o_programmed,
	output logic o_refresh_active
);
	import vrc_pkg::*;
	typedef enum logic [2:0] {ST_IDLE, ST_ACC, ST_RGNT, ST_REF, ST_XFER}
		vrc_dst_t;

	vrc_dst_t st_ff, nxt_st;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [CFG_W-1:0] cfg_ff;
	logic column_enable_low_pair_prog_ff, prog_ff, ml_prev_ff, ads_prev_ff, refresh_request_in_prev_ff;
	logic pend_a_ff, access_request_a_seen_ff, owner_b_ff, ref_int_ff, ref_ext_ff;
	logic ref_act_ff, pin_ff, ackw_n_ff, port_b_access_ack_n_ff;
	logic [RTIM_W-1:0] rtim_ff;
	logic [ROW_W-1:0] row_a_ff, act_row_ff, ref_addr_ff, maddr_ff, addr;
	logic [COL_W-1:0] col_a_ff, act_col_ff;
	logic [1:0] bank_a_ff;
	logic [NBANK-1:0] mask_ff, ras_n_ff, cas_n_ff, pre_busy, stag_mask;
	logic [NBANK-1:0] ras_on, cas_on;
	logic [XCNT_W-1:0] xcnt_ff;

	// Strobe group for a bank code under the programmed bank count
	function automatic logic [NBANK-1:0] bank_mask(input logic [1:0] b,
			input logic [1:0] cfg);
		if (cfg == BANKS_1)
			bank_mask = ALL_BANKS;
		else if (cfg == BANKS_2)
			bank_mask = b[0] ? 4'hC : 4'h3;
		else
			bank_mask = 4'h1 << b;
	endfunction : bank_mask

	// ------------------------------------------------------------
	// Decode of programming word and pins
	// ------------------------------------------------------------
	wire ml_release = ~ml_prev_ff & bus.mode_load_n;
	wire wait_mode = cfg_ff[PB_WAIT_MODE];
	wire [1:0] wait_states = cfg_ff[PB_WAIT_LSB +: 2];
	wire toggle = cfg_ff[PB_TOGGLE];
	wire [1:0] ref_type = cfg_ff[PB_REF_LSB +: 2];
	wire [1:0] bank_cfg = cfg_ff[PB_BANK_LSB +: 2];
	wire transp = cfg_ff[PB_TRANSP];
	wire pipe = cfg_ff[PB_PIPE];
	wire refresh_in_progress_mode = ~column_enable_low_pair_prog_ff;
	wire [1:0] bus_bank = {bus.bank_select_high, bus.bank_select_low};
	wire [1:0] column_enable_inputs_on = ~bus.column_enable_inputs_n;
	wire column_enable_inputs_any = |column_enable_inputs_on;
	wire ads_fall = ~bus.address_strobe_in_n & ads_prev_ff;
	wire start_a = prog_ff & ~bus.chip_select_n &
		(bus.addr_latch_en | ads_fall);
	wire [ROW_W-1:0] row_a = transp ? bus.row_addr : row_a_ff;
	wire [COL_W-1:0] col_a = transp ? bus.col_addr : col_a_ff;
	wire [1:0] bank_a = transp ? bus_bank : bank_a_ff;

	// ------------------------------------------------------------
	// Arbitration
	// ------------------------------------------------------------
	wire [NBANK-1:0] mask_a = bank_mask(bank_a, bank_cfg);
	wire [NBANK-1:0] mask_b = bank_mask(bus_bank, bank_cfg);
	wire lock = ~bus.lock_n;
	// A bank still precharging simply is not eligible yet
	wire want_a = pend_a_ff & ~|(mask_a & pre_busy) &
		~(lock & owner_b_ff);
	wire want_b = ~bus.access_request_b_n & ~|(mask_b & pre_busy) &
		~(lock & ~owner_b_ff);
	wire pick_b = want_b & ~want_a;
	wire ref_pend = ref_int_ff | ref_ext_ff;
	wire in_acc = st_ff == ST_ACC;
	wire acc_a = in_acc & ~owner_b_ff;
	wire acc_end = owner_b_ff ? bus.access_request_b_n :
		(access_request_a_seen_ff & bus.access_request_a_n);
	wire ready = (cnt_ff >= {2'h0, wait_states}) & bus.wait_extend_in_n;
	wire xdone = xcnt_ff == XFER_EDGES;
	wire stag = ref_type == REF_STAG;
	wire [CNT_W-1:0] ref_len = stag ? RAS_LOW_CYC + STAG_EXTRA : RAS_LOW_CYC;
	wire ref_end = (cnt_ff >= ref_len) & ~bus.refresh_extend_in;
	wire grant_acc = (st_ff == ST_IDLE) & (nxt_st == ST_ACC);
	wire grant_a = grant_acc & ~pick_b;
	wire grant_ref = (st_ff == ST_IDLE) & (nxt_st == ST_RGNT);
	wire ref_tick = prog_ff & (rtim_ff == REF_CYC - 11'h001);

	// Transfer enable falls with the load pin, no clock in the path; it rises with the pin or at the fourth edge
	assign bus.transfer_output_enable_n = bus.shift_reg_load_in_n | xdone;

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	// Next state; refresh outranks a waiting access, never a running one
	always_comb begin
		nxt_st = st_ff;
		nxt_cnt = (&cnt_ff) ? cnt_ff : cnt_ff + CNT_ONE;
		case (st_ff)
		ST_IDLE: begin
			nxt_cnt = CNT_ZERO;
			if (~bus.shift_reg_load_in_n & ~xdone)
				nxt_st = ST_XFER;
			else if (ref_pend)
				nxt_st = ST_RGNT;
			else if (~bus.advance_transfer_request & (want_a | want_b))
				nxt_st = ST_ACC;
		end
		ST_ACC: if (acc_end) nxt_st = ST_IDLE;
		ST_RGNT: begin
			nxt_cnt = CNT_ZERO;
			nxt_st = ST_REF;
		end
		ST_REF: if (ref_end) nxt_st = ST_IDLE;
		ST_XFER: if (bus.transfer_output_enable_n) nxt_st = ST_IDLE;
		default: nxt_st = ST_IDLE;
		endcase
	end

	// Strobe and address selection per state
	always_comb begin
		ras_on = '0;
		cas_on = '0;
		addr = act_row_ff;
		case (st_ff)
		ST_ACC: begin
			ras_on = mask_ff;
			if (cnt_ff >= RAH_CYC)
				addr = act_col_ff;
			if (cnt_ff >= CAS_CYC)
				cas_on = mask_ff &
					{column_enable_inputs_on[1], column_enable_inputs_on[1], column_enable_inputs_on[0], column_enable_inputs_on[0]};
			if (pipe & (cnt_ff > CAS_CYC))
				addr = row_a;
		end
		ST_REF: begin
			addr = ref_addr_ff;
			ras_on = stag ? stag_mask : ALL_BANKS;
			cas_on = (ref_type == REF_SCRUB) ? SCRUB_CAS : '0;
		end
		ST_XFER: begin
			ras_on = mask_ff;
			if (cnt_ff >= RAH_CYC) begin
				addr = act_col_ff;
				cas_on = mask_ff;
			end
		end
		default: addr = act_row_ff;
		endcase
	end

	// Stagger taps and per-bank precharge counters
	for (genvar i = 0; i < NBANK; i++) begin : g_bank
		assign stag_mask[i] = cnt_ff >= CNT_W'(i);
		vrc_prechg u_pre (
			.i_clk(i_clk),
			.i_resetn(i_resetn),
			.i_start(~ras_n_ff[i] & ~ras_on[i]),
			.o_busy(pre_busy[i])
		);
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// Programming is taken on the release of mode load
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cfg_ff <= CFG_RESET;
			column_enable_low_pair_prog_ff <= 1'b1;
			prog_ff <= 1'b0;
			ml_prev_ff <= 1'b1;
		end else begin
			ml_prev_ff <= bus.mode_load_n;
			if (ml_release) begin
				cfg_ff <= bus.row_addr[CFG_W-1:0];
				column_enable_low_pair_prog_ff <= bus.column_enable_inputs_n[0];
				prog_ff <= 1'b1;
			end
		end
	end

	// State, counters and ownership
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_ff <= ST_IDLE;
			cnt_ff <= CNT_ZERO;
			owner_b_ff <= 1'b0;
			xcnt_ff <= '0;
			access_request_a_seen_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			if (grant_acc)
				owner_b_ff <= pick_b;
			// Counts clock edges while the load pin is low; saturates so the end stays latched
			xcnt_ff <= bus.shift_reg_load_in_n ? '0 :
				(xdone ? xcnt_ff : xcnt_ff + 3'h1);
			access_request_a_seen_ff <= in_acc & (access_request_a_seen_ff | ~bus.access_request_a_n);
		end
	end

	// Address latches and the active row/column
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			row_a_ff <= '0;
			col_a_ff <= '0;
			bank_a_ff <= 2'h0;
			act_row_ff <= '0;
			act_col_ff <= '0;
			mask_ff <= '0;
		end else begin
			if (start_a) begin
				row_a_ff <= bus.row_addr;
				col_a_ff <= bus.col_addr;
				bank_a_ff <= bus_bank;
			end
			if (grant_acc) begin
				act_row_ff <= pick_b ? bus.row_addr : row_a;
				act_col_ff <= pick_b ? bus.col_addr : col_a;
				mask_ff <= pick_b ? mask_b : mask_a;
			end else if (nxt_st == ST_XFER && st_ff == ST_IDLE) begin
				act_row_ff <= bus.row_addr;
				act_col_ff <= bus.col_addr;
				mask_ff <= mask_b;
			end else if (in_acc & bus.column_increment_in)
				act_col_ff <= act_col_ff + 11'h001;
		end
	end

	// Refresh requests; a new request wins over the grant clear
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rtim_ff <= '0;
			ref_int_ff <= 1'b0;
			ref_ext_ff <= 1'b0;
			refresh_request_in_prev_ff <= 1'b0;
			ref_addr_ff <= '0;
			pend_a_ff <= 1'b0;
			ads_prev_ff <= 1'b1;
		end else begin
			rtim_ff <= ref_tick ? '0 : rtim_ff + 11'h001;
			ref_int_ff <= (ref_tick | (ref_int_ff & ~grant_ref)) &
				~bus.refresh_disable_in;
			refresh_request_in_prev_ff <= bus.refresh_request_in;
			ref_ext_ff <= (bus.refresh_request_in & ~refresh_request_in_prev_ff) |
				(ref_ext_ff & ~grant_ref);
			if (st_ff == ST_REF && ref_end)
				ref_addr_ff <= ref_addr_ff + 11'h001;
			pend_a_ff <= start_a | (pend_a_ff & ~grant_a);
			ads_prev_ff <= bus.address_strobe_in_n;
		end
	end

	// Registered pins
	wire ack_now = acc_a & ready & (~toggle | column_enable_inputs_any);
	wire wait_now = start_a | pend_a_ff | (acc_a & ~ready) |
		(toggle & acc_a & ~column_enable_inputs_any);
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ras_n_ff <= ALL_BANKS;
			cas_n_ff <= ALL_BANKS;
			maddr_ff <= '0;
			pin_ff <= 1'b1;
			ackw_n_ff <= 1'b1;
			port_b_access_ack_n_ff <= 1'b1;
			ref_act_ff <= 1'b0;
		end else begin
			ras_n_ff <= ~ras_on;
			cas_n_ff <= ~cas_on;
			maddr_ff <= addr;
			pin_ff <= refresh_in_progress_mode ? ~(st_ff == ST_RGNT || st_ff == ST_REF) :
				~ref_int_ff;
			ackw_n_ff <= wait_mode ? ~wait_now : ~ack_now;
			port_b_access_ack_n_ff <= ~(in_acc & owner_b_ff & ~&ras_n_ff);
			ref_act_ff <= nxt_st == ST_REF;
		end
	end

	assign bus.ras_n = ras_n_ff;
	assign bus.cas_n = cas_n_ff;
	assign bus.mem_addr = maddr_ff;
	assign bus.refresh_pin_n = pin_ff;
	assign bus.ack_wait_n = ackw_n_ff;
	assign bus.port_b_access_ack_n = port_b_access_ack_n_ff;
	assign bus.port_b_grant = owner_b_ff;
	assign o_programmed = prog_ff;
	assign o_refresh_active = ref_act_ff;
endmodule : vrc_dev_end
`default_nettype wire

/* File: hdl/vrc_host_end.sv */
// Host-side logic: processor bus sequencing toward the controller
`timescale 1ns/1ns
`default_nettype none
module vrc_host_end (
	input wire logic i_clk,
	input wire logic i_resetn,
	vrc_if.host bus,
	input wire logic i_prog_req,
	input wire logic [vrc_pkg::ROW_W-1:0] i_prog_word,
	input wire logic i_prog_refresh_in_progress,
	input wire logic i_acc_req,
	input wire logic [vrc_pkg::ROW_W-1:0] i_acc_row,
	input wire logic [vrc_pkg::COL_W-1:0] i_acc_col,
	input wire logic [1:0] i_acc_bank,
	input wire logic [1:0] i_acc_bytes,
	input wire logic i_b_req,
	input wire logic [vrc_pkg::ROW_W-1:0] i_b_row,
	input wire logic [vrc_pkg::COL_W-1:0] i_b_col,
	input wire logic [1:0] i_b_bank,
	input wire logic i_xfer_req,
	input wire logic i_ref_disable,
	input wire logic i_ref_req,
	input wire logic i_ref_follow,
	input wire logic i_ref_extend,
	input wire logic i_wait_hold,
	input wire logic i_lock,
	output logic o_busy,
	output logic o_acc_done,
	output logic o_b_done,
	output logic o_xfer_done
);
	import vrc_pkg::*;
	typedef enum logic [2:0] {HS_IDLE, HS_PROG, HS_PHOLD, HS_ASTART, HS_AWAIT,
		HS_BWAIT, HS_XLEAD, HS_XFER} vrc_hst_t;

	vrc_hst_t st_ff, nxt_st;
	logic [LEAD_W-1:0] lead_ff;
	logic [ROW_W-1:0] word_ff, row_ff;
	logic [COL_W-1:0] col_ff;
	logic [1:0] bank_ff, bytes_ff;
	logic refresh_in_progress_ff, wait_mode_ff, acc_done_ff, b_done_ff, xfer_done_ff;

	// ------------------------------------------------------------
	// Sequencing
	// ------------------------------------------------------------
	wire prog = (st_ff == HS_PROG) | (st_ff == HS_PHOLD);
	wire a_on = (st_ff == HS_ASTART) | (st_ff == HS_AWAIT);
	wire x_on = (st_ff == HS_XLEAD) | (st_ff == HS_XFER);
	wire ready = wait_mode_ff ? bus.ack_wait_n : ~bus.ack_wait_n;

	// Next state; programming first, then transfer, then accesses
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
		HS_IDLE: begin
			if (i_prog_req)
				nxt_st = HS_PROG;
			else if (i_xfer_req)
				nxt_st = HS_XLEAD;
			else if (i_acc_req)
				nxt_st = HS_ASTART;
			else if (i_b_req)
				nxt_st = HS_BWAIT;
		end
		HS_PROG: nxt_st = HS_PHOLD;
		HS_PHOLD: nxt_st = HS_IDLE;
		HS_ASTART: nxt_st = HS_AWAIT;
		HS_AWAIT: if (ready) nxt_st = HS_IDLE;
		HS_BWAIT: if (~bus.port_b_access_ack_n) nxt_st = HS_IDLE;
		// Lead time lets a running access or refresh drain first
		HS_XLEAD: if (lead_ff == XFER_LEAD_CYC) nxt_st = HS_XFER;
		HS_XFER: if (bus.transfer_output_enable_n) nxt_st = HS_IDLE;
		default: nxt_st = HS_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_ff <= HS_IDLE;
			lead_ff <= '0;
			acc_done_ff <= 1'b0;
			b_done_ff <= 1'b0;
			xfer_done_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			lead_ff <= (st_ff == HS_XLEAD) ? lead_ff + 5'h01 : '0;
			acc_done_ff <= (st_ff == HS_AWAIT) & ready;
			b_done_ff <= (st_ff == HS_BWAIT) & ~bus.port_b_access_ack_n;
			xfer_done_ff <= (st_ff == HS_XFER) & bus.transfer_output_enable_n;
		end
	end

	// Request capture; the address stays put for the whole cycle
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			word_ff <= '0;
			refresh_in_progress_ff <= 1'b0;
			wait_mode_ff <= 1'b0;
			row_ff <= '0;
			col_ff <= '0;
			bank_ff <= 2'h0;
			bytes_ff <= 2'h0;
		end else if (st_ff == HS_IDLE) begin
			if (i_prog_req) begin
				word_ff <= i_prog_word;
				refresh_in_progress_ff <= i_prog_refresh_in_progress;
				wait_mode_ff <= i_prog_word[PB_WAIT_MODE];
			end else if (i_acc_req | i_xfer_req) begin
				row_ff <= i_acc_row;
				col_ff <= i_acc_col;
				bank_ff <= i_acc_bank;
				bytes_ff <= i_acc_bytes;
			end else if (i_b_req) begin
				row_ff <= i_b_row;
				col_ff <= i_b_col;
				bank_ff <= i_b_bank;
				bytes_ff <= 2'h3;
			end
		end
	end

	// ------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------
	// Shared address bus steered by whichever port the host serves
	assign bus.row_addr = prog ? word_ff : row_ff;
	assign bus.col_addr = prog ? '0 : col_ff;
	assign bus.bank_select_low = ~prog & bank_ff[0];
	assign bus.bank_select_high = ~prog & bank_ff[1];
	assign bus.column_enable_inputs_n = prog ? {1'b1, ~refresh_in_progress_ff} : ~bytes_ff;
	assign bus.mode_load_n = ~(st_ff == HS_PROG);
	assign bus.chip_select_n = ~a_on;
	assign bus.addr_latch_en = st_ff == HS_ASTART;
	assign bus.address_strobe_in_n = 1'b1;
	assign bus.access_request_a_n = ~a_on;
	assign bus.access_request_b_n = ~(st_ff == HS_BWAIT);
	assign bus.lock_n = ~i_lock;
	assign bus.column_increment_in = 1'b0;
	assign bus.advance_transfer_request = x_on;
	assign bus.shift_reg_load_in_n = ~(st_ff == HS_XFER);
	assign bus.refresh_disable_in = i_ref_disable;
	assign bus.refresh_request_in = i_ref_req |
		(i_ref_follow & ~bus.refresh_pin_n);
	assign bus.refresh_extend_in = i_ref_extend;
	assign bus.wait_extend_in_n = ~i_wait_hold;
	assign o_busy = st_ff != HS_IDLE;
	assign o_acc_done = acc_done_ff;
	assign o_b_done = b_done_ff;
	assign o_xfer_done = xfer_done_ff;
endmodule : vrc_host_end
`default_nettype wire

/* File: tb/vrc_checker_assertions.sv */
// Concurrent checks on the pins between host logic and controller core
`timescale 1ns/1ns
`default_nettype none
module vrc_checker (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic shift_reg_load_in_n,
	input wire logic transfer_output_enable_n,
	input wire logic [3:0] ras_n,
	input wire logic access_request_a_n,
	input wire logic access_request_b_n,
	input wire logic ack_wait_n,
	input wire logic port_b_grant,
	input wire logic port_b_access_ack_n
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	// ------------------------------------------------------------
	// Steps of a transfer and of a port B ownership
	// ------------------------------------------------------------
	sequence load_held;
		!shift_reg_load_in_n [*5];
	endsequence
	sequence b_owned;
		!access_request_b_n && !port_b_access_ack_n;
	endsequence
	a_oe_at_load: assert property (
		$fell(shift_reg_load_in_n) |-> !transfer_output_enable_n)
		else $error("transfer enable late on load");
	a_xfer_before_ras: assert property (
		$fell(shift_reg_load_in_n) |-> ras_n == 4'hF)
		else $error("row strobe ahead of load");
	a_oe_load_off: assert property (
		shift_reg_load_in_n |-> transfer_output_enable_n)
		else $error("transfer enable without load");
	a_oe_four_edges: assert property (
		load_held |-> transfer_output_enable_n)
		else $error("transfer enable past four edges");
	a_ack_ends_req: assert property (
		$rose(access_request_a_n) |-> ##[0:2] ack_wait_n)
		else $error("acknowledge held after request");
	a_grant_follows_req: assert property (
		$rose(port_b_grant) |-> $past(access_request_b_n) == 1'b0)
		else $error("grant without port b request");
	a_b_owned_grant: assert property (b_owned |-> port_b_grant)
		else $error("grant low while port b owns");
	a_b_ack_after_ras: assert property (
		$fell(port_b_access_ack_n) |-> $past(ras_n) != 4'hF)
		else $error("port b ack before row strobe");
endmodule : vrc_checker
`default_nettype wire

/* File: tb/vram_controller_core_tb.sv */
// Testbench joining both ends of the video RAM controller
`timescale 1ns/1ns
`default_nettype none
module vram_controller_core_tb;
	import vrc_pkg::*;
	logic i_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic pr = 1'b0, rf = 1'b1, ar = 1'b0, br = 1'b0, xr = 1'b0;
	logic rd = 1'b1, rq = 1'b0, fo = 1'b0, ex = 1'b0, wh = 1'b0, lk = 1'b0;
	logic [10:0] pw = 11'h000, row = 11'h000, col = 11'h000;
	logic [1:0] bk = 2'h0;
	logic [3:0] lr = 4'hF, r2;
	logic la = 1'b1, lp = 1'b1, lb = 1'b1, sc, busy, prg, ract, ad, bd, xd;
	logic [10:0] a_ras;
	integer errors = 0, checks = 0, seed = 32'h4d60ec37, n, i;
	integer cyc = 0, t_ras = 0, t_ack = 0, t_wt = 0, t_pin = 0, t_rr = 0;
	integer n_oe = 0, n_ref = 0, n_b = 0;
	vrc_if bus();
	vrc_dev_end u_vrc_dev_end(.i_clk(i_clk), .i_resetn(i_resetn), .bus(bus),
		.o_programmed(prg), .o_refresh_active(ract));
	vrc_host_end u_vrc_host_end(.i_clk(i_clk), .i_resetn(i_resetn), .bus(bus),
		.i_prog_req(pr), .i_prog_word(pw), .i_prog_refresh_in_progress(rf), .i_acc_req(ar),
		.i_acc_row(row), .i_acc_col(col), .i_acc_bank(bk), .i_acc_bytes(2'h3),
		.i_b_req(br), .i_b_row(row), .i_b_col(col), .i_b_bank(bk),
		.i_xfer_req(xr), .i_ref_disable(rd), .i_ref_req(rq), .i_ref_follow(fo),
		.i_ref_extend(ex), .i_wait_hold(wh), .i_lock(lk), .o_busy(busy),
		.o_acc_done(ad), .o_b_done(bd), .o_xfer_done(xd));
	vrc_checker u_vrc_checker(.i_clk(i_clk), .i_resetn(i_resetn),
		.shift_reg_load_in_n(bus.shift_reg_load_in_n),
		.transfer_output_enable_n(bus.transfer_output_enable_n),
		.ras_n(bus.ras_n), .access_request_a_n(bus.access_request_a_n),
		.access_request_b_n(bus.access_request_b_n),
		.ack_wait_n(bus.ack_wait_n), .port_b_grant(bus.port_b_grant),
		.port_b_access_ack_n(bus.port_b_access_ack_n));
	always #(CLK_NS / 2) i_clk = ~i_clk;
	// ------------------------------------------------------------
	// Pin monitor, sampled mid-cycle where registered pins are settled
	// ------------------------------------------------------------
	always @(negedge i_clk) begin
		cyc = cyc + 1;
		// Refresh and access strobes kept apart so one never hides the other
		if (bus.ras_n !== 4'hF && lr === 4'hF) begin
			if (ract === 1'b1) begin
				t_rr = cyc;
			end else begin
				t_ras = cyc;
				a_ras = bus.mem_addr;
			end
		end
		if (cyc == t_rr + 1) r2 = bus.ras_n;
		if (bus.ras_n === 4'h0 && lr !== 4'h0 && ract === 1'b1)
			n_ref = n_ref + 1;
		if (bus.ras_n === 4'h0 && bus.cas_n[0] === 1'b0) sc = 1'b1;
		if (bus.ack_wait_n === 1'b0 && la === 1'b1) t_ack = cyc;
		if (bus.ack_wait_n === 1'b1 && la === 1'b0) t_wt = cyc;
		if (bus.refresh_pin_n === 1'b0 && lp === 1'b1) t_pin = cyc;
		if (bus.port_b_access_ack_n === 1'b0 && lb === 1'b1) n_b = n_b + 1;
		if (bus.transfer_output_enable_n === 1'b0) n_oe = n_oe + 1;
		lr = bus.ras_n;
		la = bus.ack_wait_n;
		lp = bus.refresh_pin_n;
		lb = bus.port_b_access_ack_n;
	end
	task automatic chk(input logic [10:0] got, input logic [10:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// One request from the host side; k: 0 prog, 1 A, 2 B, 3 transfer
	task automatic go(input int k, input logic [10:0] w, input logic late);
		@(posedge i_clk);
		{pr, ar, br, xr} <= 4'h8 >> k;
		pw <= w;
		row <= 11'($random(seed));
		col <= 11'($random(seed));
		bk <= 2'($random(seed));
		@(posedge i_clk);
		{pr, ar, br, xr} <= 4'h0;
		@(posedge i_clk);
		rq <= late;
		#1;
		for (n = 0; n < 400 && busy !== 1'b0; n++) @(posedge i_clk);
		repeat (3) @(posedge i_clk);
	endtask : go
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : wrap_up
	// Watchdog: the whole sequence needs well under 5000 cycles
	initial begin
		#(20000 * CLK_NS);
		errors = errors + 1;
		wrap_up();
	end
	initial begin
		repeat (20) @(posedge i_clk);
		i_resetn <= 1'b1;
		// Port A timing per wait count, a refresh raised mid-access last
		for (i = 0; i < 4; i++) begin
			go(0, 11'(i << 1), 1'b0);
			chk(11'(prg), 11'h001);
			go(1, 11'h000, i == 3);
			chk(a_ras, row);
			chk(11'(t_ack - t_ras), 11'(i));
		end
		repeat (30) @(posedge i_clk);
		chk(11'(n_ref), 11'h001);
		go(0, 11'h003, 1'b0);
		go(1, 11'h000, 1'b0);
		chk(11'(t_wt - t_ras), 11'h001);
		$display("test port a done");
		// External refresh of each type while the timer is disabled
		for (i = 0; i < 3; i++) begin
			sc = 1'b0;
			go(0, 11'(i << 4), 1'b0);
			go(0, 11'(i << 4), 1'b1);
			repeat (40) @(posedge i_clk);
			rq <= 1'b0;
			chk(11'(t_rr - t_pin), 11'h001);
			chk(11'(r2), i == 1 ? 11'h00C : 11'h000);
			chk(11'(sc), 11'(i == 2));
		end
		$display("test refresh types done");
		n_oe = 0;
		go(3, 11'h000, 1'b0);
		chk(11'(n_oe), 11'(XFER_EDGES));
		go(2, 11'h000, 1'b0);
		chk(11'(n_b), 11'h001);
		$display("test transfer and port b done");
		// Timer refresh followed through the request pin
		n_ref = 0;
		rf <= 1'b0;
		rd <= 1'b0;
		fo <= 1'b1;
		go(0, 11'h000, 1'b0);
		repeat (1700) @(posedge i_clk);
		chk(11'(n_ref != 0), 11'h001);
		$display("test timer refresh done");
		wrap_up();
	end
endmodule : vram_controller_core_tb
`default_nettype wire
